// ### fsqd_store_unit.sv
// Operation
// - Integer-word store writes low 32 FPR bits, unconverted, to the word at EA.
// - Integer-word store: primary 31, extended 983, source/base/index in bits 6-20.
// - Indexed EA is base plus index, or index alone when base field is zero.
// - Integer-word store from single-precision results may store an undefined value.
// - These stores never touch the FP status/control register or CR field 0.
// - Displacement quad: sign-extend 14-bit field to 30 bits, append two zeros.
// - Displacement quad EA is offset alone if base field zero, else base plus offset.
// - Quad writes register n at EA, register n+1 at EA+8; 31 wraps to 0.
// - Update variants write EA back to the base register when base field nonzero.
// - Displacement quad: primary 60 with sub 00, or 61 with sub 01.
// - Indexed quad: primary 31, extended 919 or 951; bit 31 is the record bit.
module fsqd_store_unit #(
    parameter bit INT_WORD_EN = 1'b1,
    parameter bit QUAD_EN     = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        clkEn,
    // Issue side
    input  wire logic        insnValid,
    input  wire logic [31:0] insn,
    output logic             insnReady,
    output logic             illegalInsn,
    output logic             insnClaimed,
    // Register read ports
    output logic [4:0]       gprRdAddrA,
    output logic [4:0]       gprRdAddrB,
    input  wire logic [31:0] gprRdDataA,
    input  wire logic [31:0] gprRdDataB,
    output logic [4:0]       fprRdAddr,
    input  wire logic [63:0] fprRdData,
    // Base register update
    output logic             gprWrEn,
    output logic [4:0]       gprWrAddr,
    output logic [31:0]      gprWrData,
    // Memory store port
    output logic             memValid,
    input  wire logic        memReady,
    output logic [31:0]      memAddr,
    output logic [63:0]      memData,
    output logic             memDword
);
    typedef enum logic [1:0] {FSQD_IDLE, FSQD_FIRST, FSQD_SECOND} fsqd_state_t;

    fsqd_pkg::fsqd_op_t decOp;
    logic               decUpdate;
    logic [4:0]         fieldSrc;
    logic [4:0]         fieldBase;
    logic [4:0]         fieldIndex;
    logic [13:0]        fieldDisp;
    logic [31:0]        dispOffset;
    logic [31:0]        baseTerm;
    logic [31:0]        ea;

    fsqd_state_t        state,      next_state;
    logic [31:0]        addrReg,    next_addrReg;
    logic [4:0]         srcReg,     next_srcReg;
    logic               quadReg,    next_quadReg;
    logic [63:0]        dataReg,    next_dataReg;
    logic               illegal,    next_illegal;
    logic               wrEn,       next_wrEn;
    logic [4:0]         wrAddr,     next_wrAddr;
    logic [31:0]        wrData,     next_wrData;

    fsqd_decode #(
        .INT_WORD_EN (INT_WORD_EN),
        .QUAD_EN     (QUAD_EN)
    ) u_decode (
        .insn       (insn),
        .opKind     (decOp),
        .updateBase (decUpdate),
        .recordBit  ()
    );

    assign fieldSrc   = insn[25:21];
    assign fieldBase  = insn[20:16];
    assign fieldIndex = insn[15:11];
    assign fieldDisp  = insn[15:2];
    // Record bit has no effect: CR0 and FPSCR are never written by this unit
    assign dispOffset = {{16{fieldDisp[13]}}, fieldDisp, 2'b00};
    assign baseTerm   = (fieldBase == 5'h00) ? 32'h0000_0000 : gprRdDataA;
    assign ea         = baseTerm + ((decOp == fsqd_pkg::FSQD_OP_QUAD_D) ? dispOffset : gprRdDataB);

    assign gprRdAddrA = fieldBase;
    assign gprRdAddrB = fieldIndex;
    // Read port follows the state so the second register is fetched one beat later
    assign fprRdAddr  = (state == FSQD_IDLE) ? fieldSrc : srcReg;

    assign insnReady   = (state == FSQD_IDLE) && clkEn;
    assign insnClaimed = insnReady && insnValid && (decOp != fsqd_pkg::FSQD_OP_NONE);
    assign memValid    = (state != FSQD_IDLE);
    assign memAddr     = addrReg;
    assign memData     = dataReg;
    assign memDword    = quadReg;
    assign illegalInsn = illegal;
    assign gprWrEn     = wrEn;
    assign gprWrAddr   = wrAddr;
    assign gprWrData   = wrData;

    always_comb begin
        next_state   = state;
        next_addrReg = addrReg;
        next_srcReg  = srcReg;
        next_quadReg = quadReg;
        next_dataReg = dataReg;
        next_illegal = 1'b0;
        next_wrEn    = 1'b0;
        next_wrAddr  = wrAddr;
        next_wrData  = wrData;
        unique case (state)
            FSQD_IDLE: begin
                if (insnValid) begin
                    unique case (decOp)
                        fsqd_pkg::FSQD_OP_INT_WORD: begin
                            next_state   = FSQD_SECOND;
                            next_addrReg = ea;
                            next_quadReg = 1'b0;
                            // Raw bits; single-precision sourced values are stored as-is
                            next_dataReg = {32'h0000_0000, fprRdData[31:0]};
                        end
                        fsqd_pkg::FSQD_OP_QUAD_D, fsqd_pkg::FSQD_OP_QUAD_X: begin
                            next_state   = FSQD_FIRST;
                            next_addrReg = ea;
                            next_quadReg = 1'b1;
                            next_dataReg = fprRdData;
                            next_srcReg  = fieldSrc + 5'h01;
                            if (decUpdate && fieldBase != 5'h00) begin
                                next_wrEn   = 1'b1;
                                next_wrAddr = fieldBase;
                                next_wrData = ea;
                            end
                        end
                        fsqd_pkg::FSQD_OP_ILLEGAL: next_illegal = 1'b1;
                        default: ;
                    endcase
                end
            end
            FSQD_FIRST: begin
                if (memReady) begin
                    next_state   = FSQD_SECOND;
                    next_addrReg = addrReg + fsqd_pkg::SECOND_DW_OFFSET;
                    next_dataReg = fprRdData;
                end
            end
            FSQD_SECOND: begin
                if (memReady) begin
                    next_state = FSQD_IDLE;
                end
            end
            default: next_state = FSQD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state   <= FSQD_IDLE;
            addrReg <= 32'h0000_0000;
            srcReg  <= 5'h00;
            quadReg <= 1'b0;
            dataReg <= 64'h0000_0000_0000_0000;
            illegal <= 1'b0;
            wrEn    <= 1'b0;
            wrAddr  <= 5'h00;
            wrData  <= 32'h0000_0000;
        end else if (clkEn) begin
            state   <= next_state;
            addrReg <= next_addrReg;
            srcReg  <= next_srcReg;
            quadReg <= next_quadReg;
            dataReg <= next_dataReg;
            illegal <= next_illegal;
            wrEn    <= next_wrEn;
            wrAddr  <= next_wrAddr;
            wrData  <= next_wrData;
        end
    end

    a_quad_second_addr: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && state == FSQD_FIRST && memReady) |=> (memAddr == $past(memAddr) + 32'h0000_0008))
        else $error("second doubleword not at EA+8");
    a_wrap_src: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decOp == fsqd_pkg::FSQD_OP_QUAD_D && fieldSrc == 5'h1F)
        |=> (fprRdAddr == 5'h00))
        else $error("register 31 did not wrap to 0");
    a_word_data: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decOp == fsqd_pkg::FSQD_OP_INT_WORD)
        |=> (memValid && !memDword && memData[31:0] == $past(fprRdData[31:0])))
        else $error("integer word data wrong");
    a_update_base: assert property (@(posedge core_clk) disable iff (!nrst)
        gprWrEn |-> (gprWrAddr != 5'h00 && gprWrData == memAddr && memDword))
        else $error("base update wrong");
    a_update_issue: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decUpdate && fieldBase != 5'h00
            && (decOp == fsqd_pkg::FSQD_OP_QUAD_D || decOp == fsqd_pkg::FSQD_OP_QUAD_X))
        |=> (gprWrEn && gprWrAddr == $past(fieldBase)))
        else $error("base update missing");
    a_disp_ea: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decOp == fsqd_pkg::FSQD_OP_QUAD_D && fieldBase == 5'h00)
        |=> (memAddr == {{16{$past(insn[15])}}, $past(insn[15:2]), 2'b00}))
        else $error("displacement EA wrong");
    a_disp_base_ea: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decOp == fsqd_pkg::FSQD_OP_QUAD_D && fieldBase != 5'h00)
        |=> (memAddr == $past(gprRdDataA) + {{16{$past(insn[15])}}, $past(insn[15:2]), 2'b00}))
        else $error("base plus displacement EA wrong");
    a_index_ea: assert property (@(posedge core_clk) disable iff (!nrst)
        (clkEn && insnReady && insnValid && decOp == fsqd_pkg::FSQD_OP_QUAD_X && fieldBase != 5'h00)
        |=> (memAddr == $past(gprRdDataA) + $past(gprRdDataB)))
        else $error("indexed EA wrong");
    a_illegal_nostore: assert property (@(posedge core_clk) disable iff (!nrst)
        illegalInsn |-> (!memValid && !gprWrEn))
        else $error("illegal encoding caused a store");
    a_word_decode: assert property (@(posedge core_clk) disable iff (!nrst)
        (decOp == fsqd_pkg::FSQD_OP_INT_WORD) |-> (insn[31:26] == 6'h1F && insn[10:1] == 10'h3D7))
        else $error("integer word misdecode");
    a_quad_decode: assert property (@(posedge core_clk) disable iff (!nrst)
        (decOp == fsqd_pkg::FSQD_OP_QUAD_D) |-> ((insn[31:26] == 6'h3C && insn[1:0] == 2'h0)
            || (insn[31:26] == 6'h3D && insn[1:0] == 2'h1)))
        else $error("displacement quad misdecode");
    // A stalled core must neither advance nor drop a pending beat
    a_freeze_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        !clkEn |=> ($stable(memValid) && $stable(memAddr) && $stable(memData) && $stable(gprWrEn)))
        else $error("state moved while clock enable was low");
endmodule

// ### fsqd_pkg.sv
package fsqd_pkg;
    localparam int          INSN_W      = 32;
    localparam int          ADDR_W      = 32;
    localparam int          FPR_W       = 64;
    localparam int          GPR_W       = 32;
    localparam int          REG_IDX_W   = 5;
    localparam logic [5:0]  OP_PRIMARY_X     = 6'h1F;
    localparam logic [5:0]  OP_QUAD_D        = 6'h3C;
    localparam logic [5:0]  OP_QUAD_DU       = 6'h3D;
    localparam logic [9:0]  XOP_INT_WORD     = 10'h3D7;
    localparam logic [9:0]  XOP_QUAD_X       = 10'h397;
    localparam logic [9:0]  XOP_QUAD_XU      = 10'h3B7;
    localparam logic [1:0]  DS_SUB_PLAIN     = 2'h0;
    localparam logic [1:0]  DS_SUB_UPDATE    = 2'h1;
    localparam int          DISP_W           = 14;
    localparam logic [ADDR_W-1:0] SECOND_DW_OFFSET = 32'h0000_0008;
    // Instruction field positions, little-endian bit 0 = LSB
    localparam int          OPC_LSB     = 26;
    localparam int          SRC_LSB     = 21;
    localparam int          BASE_LSB    = 16;
    localparam int          INDEX_LSB   = 11;
    localparam int          XOP_LSB     = 1;
    localparam int          DISP_LSB    = 2;
    localparam int          SUB_LSB     = 0;
    localparam logic [3:0]  BYTE_EN_WORD  = 4'h0;
    localparam logic [3:0]  BYTE_EN_DWORD = 4'h1;
    typedef enum logic [2:0] {
        FSQD_OP_NONE,
        FSQD_OP_INT_WORD,
        FSQD_OP_QUAD_D,
        FSQD_OP_QUAD_X,
        FSQD_OP_ILLEGAL
    } fsqd_op_t;
endpackage

// ### fsqd_decode.sv
module fsqd_decode #(
    parameter bit INT_WORD_EN = 1'b1,
    parameter bit QUAD_EN     = 1'b1
) (
    input  wire logic [31:0]      insn,
    output fsqd_pkg::fsqd_op_t    opKind,
    output logic                  updateBase,
    output logic                  recordBit
);
    logic [5:0] primary;
    logic [9:0] xop;
    logic [1:0] sub;
    assign primary   = insn[31:26];
    assign xop       = insn[10:1];
    assign sub       = insn[1:0];
    assign recordBit = insn[0];

    always_comb begin
        opKind     = fsqd_pkg::FSQD_OP_NONE;
        updateBase = 1'b0;
        if (primary == fsqd_pkg::OP_PRIMARY_X) begin
            if (xop == fsqd_pkg::XOP_INT_WORD) begin
                opKind = INT_WORD_EN ? fsqd_pkg::FSQD_OP_INT_WORD : fsqd_pkg::FSQD_OP_ILLEGAL;
            end else if (xop == fsqd_pkg::XOP_QUAD_X || xop == fsqd_pkg::XOP_QUAD_XU) begin
                opKind     = QUAD_EN ? fsqd_pkg::FSQD_OP_QUAD_X : fsqd_pkg::FSQD_OP_ILLEGAL;
                updateBase = (xop == fsqd_pkg::XOP_QUAD_XU);
            end
        end else if ((primary == fsqd_pkg::OP_QUAD_D && sub == fsqd_pkg::DS_SUB_PLAIN)
                  || (primary == fsqd_pkg::OP_QUAD_DU && sub == fsqd_pkg::DS_SUB_UPDATE)) begin
            opKind     = QUAD_EN ? fsqd_pkg::FSQD_OP_QUAD_D : fsqd_pkg::FSQD_OP_ILLEGAL;
            updateBase = (primary == fsqd_pkg::OP_QUAD_DU);
        end
    end
endmodule

// ### fsqd_far_model.sv
module fsqd_far_model (
    input  wire logic        core_clk,
    input  wire logic        slow,
    input  wire logic [4:0]  gprRdAddrA,
    input  wire logic [4:0]  gprRdAddrB,
    output logic      [31:0] gprRdDataA,
    output logic      [31:0] gprRdDataB,
    input  wire logic [4:0]  fprRdAddr,
    output logic      [63:0] fprRdData,
    input  wire logic        gprWrEn,
    input  wire logic [4:0]  gprWrAddr,
    input  wire logic [31:0] gprWrData,
    input  wire logic        memValid,
    output logic             memReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gpr [32];
    logic        tick;
    initial begin
        tick = 1'b0;
        for (int i = 0; i < 32; i++) begin
            gpr[i] = 32'h1000_0000 + 32'(i) * 32'h0000_0100;
        end
    end
    always @(posedge core_clk) begin
        tick <= ~tick;
        if (gprWrEn) begin
            gpr[gprWrAddr] <= gprWrData;
        end
    end
    assign gprRdDataA = gpr[gprRdAddrA];
    assign gprRdDataB = gpr[gprRdAddrB];
    // Contents depend only on the index, so the bench can derive them
    assign fprRdData = {8'hF0, 19'h0, fprRdAddr, 8'h0A, 19'h0, fprRdAddr};
    // Slow mode accepts on alternate cycles to stretch each beat
    assign memReady = memValid && (!slow || tick);
endmodule

// ### test_fp_store_word_quad_decode.sv
module test_fp_store_word_quad_decode;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, clkEn, insnValid, slow, insnReady, illegalInsn, insnClaimed;
    logic gprWrEn, memValid, memReady, memDword;
    logic [31:0] insn, gprRdDataA, gprRdDataB, gprWrData, memAddr;
    logic [63:0] fprRdData, memData;
    logic [4:0]  gprRdAddrA, gprRdAddrB, fprRdAddr, gprWrAddr;
    logic [31:0] gprMirror [32];
    int          fail_count = 0;
    int          comparisons = 0;
    logic        offValid, offClaimed, offIllegal, offMemValid, offWrEn;

    fsqd_store_unit dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .insnValid(insnValid), .insn(insn),
        .insnReady(insnReady), .illegalInsn(illegalInsn), .insnClaimed(insnClaimed), .gprRdAddrA(gprRdAddrA),
        .gprRdAddrB(gprRdAddrB), .gprRdDataA(gprRdDataA), .gprRdDataB(gprRdDataB), .fprRdAddr(fprRdAddr),
        .fprRdData(fprRdData), .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData),
        .memValid(memValid), .memReady(memReady), .memAddr(memAddr), .memData(memData), .memDword(memDword));
    fsqd_far_model far (.core_clk(core_clk), .slow(slow), .gprRdAddrA(gprRdAddrA), .gprRdAddrB(gprRdAddrB),
        .gprRdDataA(gprRdDataA), .gprRdDataB(gprRdDataB), .fprRdAddr(fprRdAddr), .fprRdData(fprRdData),
        .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData), .memValid(memValid), .memReady(memReady));
    // Both encodings disabled: every one of ours must be claimed and flagged illegal, never stored
    fsqd_store_unit #(.INT_WORD_EN(1'b0), .QUAD_EN(1'b0)) dutOff (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn),
        .insnValid(offValid), .insn(insn), .insnReady(), .illegalInsn(offIllegal), .insnClaimed(offClaimed),
        .gprRdAddrA(), .gprRdAddrB(), .gprRdDataA(32'h0000_0000), .gprRdDataB(32'h0000_0000), .fprRdAddr(),
        .fprRdData(64'h0000_0000_0000_0000), .gprWrEn(offWrEn), .gprWrAddr(), .gprWrData(),
        .memValid(offMemValid), .memReady(offMemValid), .memAddr(), .memData(), .memDword());

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xf(logic [4:0] s, logic [4:0] a, logic [4:0] b, logic [9:0] x, logic r);
        return {fsqd_pkg::OP_PRIMARY_X, s, a, b, x, r};
    endfunction
    function automatic logic [31:0] df(logic [5:0] op, logic [4:0] s, logic [4:0] a, logic [13:0] d, logic [1:0] u);
        return {op, s, a, d, u};
    endfunction
    function automatic logic [31:0] eaX(logic [4:0] a, logic [4:0] b);
        return (a != 5'h00 ? gprMirror[a] : 32'h0000_0000) + gprMirror[b];
    endfunction
    function automatic logic [31:0] eaD(logic [4:0] a, logic [13:0] d);
        return (a != 5'h00 ? gprMirror[a] : 32'h0000_0000) + {{16{d[13]}}, d, 2'b00};
    endfunction

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Offers one store, then follows every beat to the end with a bounded wait
    task automatic run(input logic [31:0] w, input int beats, input logic [31:0] ea, input logic upd);
        int          n;
        logic [4:0]  s;
        logic [63:0] d;
        n = 0;
        while (!insnReady && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        insn = w;
        insnValid = 1'b1;
        #5;
        check("insnClaimed", 64'(1'b1), 64'(insnClaimed));
        @(posedge core_clk);
        #1;
        insnValid = 1'b0;
        check("gprWrEn", 64'(upd), 64'(gprWrEn));
        check("illegalInsn", 64'(1'b0), 64'(illegalInsn));
        if (upd) begin
            check("gprWrAddr", 64'(w[20:16]), 64'(gprWrAddr));
            check("gprWrData", 64'(ea), 64'(gprWrData));
            gprMirror[w[20:16]] = ea;
        end
        for (int b = 0; b < beats; b++) begin
            n = 0;
            while (!(memValid && memReady) && n < 20) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            check("memValid", 64'(1'b1), 64'(memValid));
            s = w[25:21] + 5'(b);
            d = {8'hF0, 19'h0, s, 8'h0A, 19'h0, s};
            check("memAddr", 64'(ea + 32'(b) * 32'h0000_0008), 64'(memAddr));
            check("memData", beats == 2 ? d : {32'h0, d[31:0]}, memData);
            check("memDword", 64'(beats == 2), 64'(memDword));
            @(posedge core_clk);
            #1;
        end
        check("memValid", 64'(1'b0), 64'(memValid));
    endtask

    task automatic t_int_word;
        run(xf(5'd6, 5'd5, 5'd4, fsqd_pkg::XOP_INT_WORD, 1'b0), 1, eaX(5'd5, 5'd4), 1'b0);
        run(xf(5'd31, 5'd0, 5'd9, fsqd_pkg::XOP_INT_WORD, 1'b0), 1, eaX(5'd0, 5'd9), 1'b0);
        $display("test int word done");
    endtask

    task automatic t_quad_disp;
        run(df(fsqd_pkg::OP_QUAD_D, 5'd31, 5'd3, 14'h3FFE, fsqd_pkg::DS_SUB_PLAIN), 2, eaD(5'd3, 14'h3FFE), 1'b0);
        run(df(fsqd_pkg::OP_QUAD_D, 5'd4, 5'd0, 14'h2000, fsqd_pkg::DS_SUB_PLAIN), 2, eaD(5'd0, 14'h2000), 1'b0);
        $display("test quad disp done");
    endtask

    task automatic t_quad_upd;
        slow = 1'b1;
        run(df(fsqd_pkg::OP_QUAD_DU, 5'd10, 5'd7, 14'h1FFF, fsqd_pkg::DS_SUB_UPDATE), 2, eaD(5'd7, 14'h1FFF), 1'b1);
        run(df(fsqd_pkg::OP_QUAD_DU, 5'd12, 5'd0, 14'h0004, fsqd_pkg::DS_SUB_UPDATE), 2, eaD(5'd0, 14'h0004), 1'b0);
        slow = 1'b0;
        $display("test quad update done");
    endtask

    task automatic t_quad_idx;
        run(xf(5'd20, 5'd7, 5'd8, fsqd_pkg::XOP_QUAD_X, 1'b1), 2, eaX(5'd7, 5'd8), 1'b0);
        run(xf(5'd31, 5'd7, 5'd2, fsqd_pkg::XOP_QUAD_XU, 1'b1), 2, eaX(5'd7, 5'd2), 1'b1);
        $display("test quad indexed done");
    endtask

    task automatic t_ignored;
        logic [31:0] foreign [3];
        foreign = '{df(6'h36, 5'd1, 5'd2, 14'h0010, 2'h0), df(fsqd_pkg::OP_QUAD_D, 5'd1, 5'd2, 14'h0010, 2'h1),
                    xf(5'd1, 5'd2, 5'd3, 10'h2D7, 1'b0)};
        foreach (foreign[i]) begin
            insn = foreign[i];
            insnValid = 1'b1;
            #5;
            check("insnClaimed", 64'(1'b0), 64'(insnClaimed));
            @(posedge core_clk);
            #1;
            check("memValid", 64'(1'b0), 64'(memValid));
            check("gprWrEn", 64'(1'b0), 64'(gprWrEn));
        end
        insnValid = 1'b0;
        $display("test ignored done");
    endtask

    task automatic t_disabled;
        logic [31:0] enc [3];
        enc = '{xf(5'd1, 5'd2, 5'd3, fsqd_pkg::XOP_INT_WORD, 1'b0),
                df(fsqd_pkg::OP_QUAD_DU, 5'd1, 5'd2, 14'h0010, fsqd_pkg::DS_SUB_UPDATE),
                xf(5'd1, 5'd2, 5'd3, fsqd_pkg::XOP_QUAD_X, 1'b0)};
        foreach (enc[i]) begin
            insn = enc[i];
            offValid = 1'b1;
            #5;
            check("offClaimed", 64'(1'b1), 64'(offClaimed));
            @(posedge core_clk);
            #1;
            offValid = 1'b0;
            check("offIllegal", 64'(1'b1), 64'(offIllegal));
            check("offMemValid", 64'(1'b0), 64'(offMemValid));
            check("offWrEn", 64'(1'b0), 64'(offWrEn));
            @(posedge core_clk);
            #1;
            check("offIllegal", 64'(1'b0), 64'(offIllegal));
        end
        $display("test disabled encodings done");
    endtask

    // Stalls a quad store in flight, resets it during its second beat, then recovers
    task automatic t_freeze;
        logic [31:0] ea;
        ea = eaD(5'd3, 14'h0010);
        insn = df(fsqd_pkg::OP_QUAD_D, 5'd2, 5'd3, 14'h0010, fsqd_pkg::DS_SUB_PLAIN);
        insnValid = 1'b1;
        @(posedge core_clk);
        #1;
        insnValid = 1'b0;
        clkEn = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("insnReady", 64'(1'b0), 64'(insnReady));
        check("memValid", 64'(1'b1), 64'(memValid));
        check("memAddr", 64'(ea), 64'(memAddr));
        clkEn = 1'b1;
        @(posedge core_clk);
        #1;
        check("memAddr", 64'(ea + 32'h0000_0008), 64'(memAddr));
        check("memData", {8'hF0, 19'h0, 5'd3, 8'h0A, 19'h0, 5'd3}, memData);
        nrst = 1'b0;
        #1;
        check("memValid", 64'(1'b0), 64'(memValid));
        @(posedge core_clk);
        #1;
        nrst = 1'b1;
        run(xf(5'd1, 5'd0, 5'd6, fsqd_pkg::XOP_INT_WORD, 1'b0), 1, eaX(5'd0, 5'd6), 1'b0);
        $display("test freeze and reset done");
    endtask

    initial begin
        nrst = 1'b0;
        clkEn = 1'b1;
        insnValid = 1'b0;
        insn = 32'h0000_0000;
        offValid = 1'b0;
        slow = 1'b0;
        for (int i = 0; i < 32; i++) begin
            gprMirror[i] = 32'h1000_0000 + 32'(i) * 32'h0000_0100;
        end
        repeat (3) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        t_int_word;
        t_quad_disp;
        t_quad_upd;
        t_quad_idx;
        t_ignored;
        t_disabled;
        t_freeze;
        end_sim;
    end

    initial begin
        #(40 * 3000);
        fail_count++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim;
    end
endmodule
